/* File: bench/lsd_glass_model.sv */
module lsd_glass_model (
	input wire core_clk,
	input wire [8:0] com_out,
	input wire [59:0] seg_out,
	output logic [3:0] lit_com,
	output logic [59:0] lit_seg
);
	timeunit 1ns;
	timeprecision 1ns;
	// Holds the pattern shown under the last selected common
	always @(posedge core_clk)
		for (int i = 0; i < 9; i++)
			if (com_out[i]) begin
				lit_com <= 4'(i);
				lit_seg <= seg_out;
			end
endmodule // lsd_glass_model

/* File: bench/lsd_scan_driver_properties.sv */
module lsd_scan_props #(parameter SEG_COUNT = 60) (
	input wire core_clk,
	input wire srst,
	input wire [1:0] duty_select_option,
	input wire osc_is_crystal,
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire avs_waitrequest,
	input wire [8:0] com_out,
	input wire [SEG_COUNT-1:0] seg_out,
	input wire pump_clk,
	input wire frame_pulse,
	input wire sixth_io_port_release
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] duty, up;
	logic f_arm, p_arm, pon, prate;
	logic [12:0] f_cnt, p_cnt;
	wire ctrl_wr = avs_write && avs_address == 12'h050;
	wire wr_done = avs_write && !avs_waitrequest;
	wire [12:0] p_exp = duty != 2'h0 ? 13'h0C35 : prate ? 13'h061A : 13'h030D;
	// Copy of pump on and pump rate as software left them
	always @(posedge core_clk) begin
		if (srst) begin
			pon <= 1'b0;
			prate <= 1'b0;
		end else if (wr_done && avs_address == 12'h050)
			pon <= avs_writedata[1];
		else if (wr_done && avs_address == 12'h070 && !pon)
			prate <= avs_writedata[2];
	end
	wire [12:0] f_exp = (duty == 2'h0 ? 13'h0360 : duty == 2'h2 ? 13'h0380 : 13'h0370) << (osc_is_crystal ? 0 : 2);
	// Strap copy, frame and pump interval counters
	always @(posedge core_clk) begin
		if (srst)
			duty <= duty_select_option;
		up <= srst ? 2'h0 : up + {1'b0, up != 2'h3};
		f_cnt <= frame_pulse ? 13'h0001 : f_cnt + 1'b1;
		p_cnt <= $changed(pump_clk) ? 13'h0001 : p_cnt + 1'b1;
		f_arm <= !srst && com_out != 9'h000 && !$changed(osc_is_crystal) && (f_arm || frame_pulse);
		p_arm <= !srst && pon && !ctrl_wr && (p_arm || $changed(pump_clk));
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
	one_com_a: assert property ($onehot0(com_out)) else $error("commons not one-hot");
	blank_seg_a: assert property (com_out == 9'h000 |-> seg_out == '0) else $error("segments live");
	com_step_a: assert property ($past(com_out) != 9'h000 && com_out != 9'h000 && $changed(com_out) |->
		com_out == $past(com_out) << 1 || com_out == (duty == 2'h0 ? 9'h001 : 9'h010) &&
		$past(com_out) == (duty == 2'h2 ? 9'h080 : 9'h100)) else $error("bad common order");
	frame_len_a: assert property (frame_pulse && f_arm |-> f_cnt == f_exp) else $error("bad frame length");
	pump_half_a: assert property ($changed(pump_clk) && p_arm |-> p_cnt == p_exp) else $error("bad pump rate");
	port_rel_a: assert property (up == 2'h3 |-> sixth_io_port_release == (duty != 2'h0)) else $error("bad release");
	com_range_a: assert property (duty != 2'h0 |-> com_out[3:0] == 4'h0 && !(duty == 2'h2 && com_out[8]))
		else $error("common out of mode");
	cover property (frame_pulse && f_arm);
	cover property ($changed(pump_clk) && p_arm);
	cover property (avs_read && !avs_waitrequest);
endmodule // lsd_scan_props

bind lsd_scan_driver lsd_scan_props #(.SEG_COUNT(SEG_COUNT)) u_props (.core_clk, .srst, .duty_select_option,
	.osc_is_crystal, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .com_out, .seg_out, .pump_clk,
	.frame_pulse, .sixth_io_port_release);

/* File: bench/lsd_scan_driver_test.sv */
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("ERROR %0t mismatch", $time); end end
module lsd_scan_driver_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 0, srst = 1, osc_is_crystal = 1, avs_read = 0, avs_write = 0;
	logic [1:0] duty_select_option = 2'h0;
	logic [11:0] avs_address = 12'h000;
	logic [31:0] avs_writedata = 32'h0000_0000, rd;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, pump_clk, frame_pulse, sixth_io_port_release;
	wire [8:0] com_out;
	wire [59:0] seg_out, lit_seg;
	wire [3:0] lit_com;
	logic [3:0] mem [0:2][0:59];
	int bad_count = 0, compares = 0;
	always #20 core_clk = ~core_clk;
	lsd_scan_driver dut_u (.core_clk, .srst, .duty_select_option, .osc_is_crystal, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .com_out, .seg_out, .pump_clk,
		.frame_pulse, .sixth_io_port_release);
	lsd_glass_model glass_u (.core_clk, .com_out, .seg_out, .lit_com, .lit_seg);
	function automatic logic [59:0] exp_seg(input int c);
		for (int k = 0; k < 60; k++)
			exp_seg[k] = c < 8 ? mem[c / 4][k][c % 4] : mem[2][k][0];
	endfunction
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge core_clk); while (avs_waitrequest);
		rd = avs_readdata;
		avs_write <= 0;
		avs_read <= 0;
		@(posedge core_clk);
	endtask
	task automatic t_reset(input logic [1:0] dt, input logic o);
		srst <= 1;
		duty_select_option <= dt;
		osc_is_crystal <= o;
		repeat (3) @(posedge core_clk);
		srst <= 0;
		@(posedge core_clk);
	endtask
	task automatic t_regs;
		bus(0, 12'h050, 0);
		`CHK(rd, 32'h0000_0000)
		bus(0, 12'h070, 0);
		`CHK(rd, 32'h0000_0000)
		bus(1, 12'h000, 32'hFFFF_FFFF);
		bus(0, 12'h000, 0);
		`CHK(rd, 32'h0000_0000)
		bus(1, 12'hD00, 32'hFFFF_FFFF);
		bus(0, 12'hD00, 0);
		`CHK(rd, 32'h0000_000F)
	endtask
	task automatic t_scan(input logic [1:0] dt, input logic o, input logic r, input int nc, input int hold);
		int sl, base;
		sl = (dt == 2'h0 ? 96 : dt == 2'h2 ? 224 : 176) * (o ? 1 : 4);
		base = nc == 9 ? 0 : 4;
		t_reset(dt, o);
		for (int b = 0; b < 3; b++)
			for (int k = 0; k < 60; k++) begin
				mem[b][k] = 4'(k * 7 + b * 3 + nc);
				bus(1, 12'hC00 + 12'(b * 256 + k * 4), 32'(mem[b][k]));
			end
		bus(1, 12'h070, 32'(r) << 2);
		bus(1, 12'h050, 32'h0000_0002);
		bus(1, 12'h070, 32'(!r) << 2);
		bus(0, 12'h070, 0);
		`CHK(rd, 32'(r) << 2)
		repeat (hold) @(posedge core_clk);
		bus(1, 12'h050, 32'h0000_0006);
		@(posedge frame_pulse);
		repeat (4) @(negedge core_clk);
		for (int i = 0; i < nc; i++) begin
			`CHK(lit_com, 4'(base + i))
			`CHK(lit_seg, exp_seg(base + i))
			repeat (sl) @(negedge core_clk);
		end
		`CHK(sixth_io_port_release, dt != 2'h0)
		@(posedge core_clk);
		bus(1, 12'h050, 32'h0000_0004);
		repeat (3) @(negedge core_clk);
		`CHK({com_out, seg_out}, 69'h0)
		@(posedge core_clk);
		bus(1, 12'h050, 32'h0000_0002);
		repeat (3) @(negedge core_clk);
		`CHK({com_out, seg_out}, 69'h0)
		@(posedge core_clk);
	endtask
	task automatic finish_test;
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#2_000_000;
		bad_count++;
		finish_test;
	end
	initial begin
		t_reset(2'h0, 1);
		t_regs;
		t_scan(2'h0, 1, 0, 9, 2000);
		t_scan(2'h1, 1, 0, 5, 0);
		t_scan(2'h2, 1, 0, 4, 7000);
		t_scan(2'h3, 1, 0, 5, 0);
		t_scan(2'h0, 0, 1, 9, 4000);
		finish_test;
	end
endmodule // lsd_scan_driver_test

/* File: src/lsd_consts.vh */
`ifndef LSD_CONSTS_VH
`define LSD_CONSTS_VH

// ---------------------------------------------------------------
// Register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define LSD_IDX_CTRL 10'h014
`define LSD_IDX_PUMPCFG 10'h01C
`define LSD_IDX_STATUS 10'h01D
`define LSD_IDX_BANK_A 10'h300
`define LSD_IDX_BANK_A_END 10'h33B
`define LSD_IDX_BANK_B 10'h340
`define LSD_IDX_BANK_B_END 10'h37B
`define LSD_IDX_BANK_C 10'h380
`define LSD_IDX_BANK_C_END 10'h3BB

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define LSD_BIT_PUMP_ON 1
`define LSD_BIT_DISP_ON 2
`define LSD_BIT_PUMP_RATE 2
`define LSD_RST_PUMP_ON 1'b0
`define LSD_RST_DISP_ON 1'b0
`define LSD_RST_PUMP_RATE 1'b0

// ---------------------------------------------------------------
// Duty option codes
// ---------------------------------------------------------------
`define LSD_DUTY_9COM_Q 2'b00
`define LSD_DUTY_5COM_Q 2'b01
`define LSD_DUTY_4COM_T 2'b10
`define LSD_DUTY_5COM_T 2'b11

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LSD_CORE_HZ 25000000
`define LSD_PUMP_SLOW_HZ 4000
`define LSD_PUMP_FAST_HZ 16000
`define LSD_PUMP_MID_HZ 8000
`define LSD_FRAME_DIV_4COM 448
`define LSD_FRAME_DIV_5COM 440
`define LSD_FRAME_DIV_9COM 432
`define LSD_RC_PRESCALE 4

`endif

/* File: src/lsd_scan_driver.v */
// Summary of operation
// (RL1) Nine-common mode: nibbles 300h-33Bh, bits 0-3 drive commons 1-4, segments 1-60.
// (RL2) Nine-common mode: nibbles 340h-37Bh, bits 0-3 drive commons 5-8.
// (RL3) Nine-common mode: bit 0 of 380h-3BBh drives common 9; other bits unused.
// (RL4) Four-common mode scans only 340h-37Bh, bits onto commons 5-8.
// (RL5) Five-common mode: 340h-37Bh for commons 5-8, bit 0 of 380h-3BBh for fifth.
// (RL6) Pump clock 4kHz in four/five modes, 16kHz or 8kHz in nine mode.
// (RL7) Frame equals display clock over 448x2, 440x2 or 432x2 per mode.
// (RL8) Display clock is oscillator for crystal, oscillator divided by four for RC.
// (RL9) Pump enable at 0 forces all commons and segments to ground.
// (RL10) Software sets pump on, halts, resumes no earlier than 250ms later.
// (RL11) Software enables display only after memory init and pump settling.
// (RL12) Two-bit duty option: 00 nine, 01 five, 10 four, 11 five commons.
// (RL13) Display off drives every common and segment low.
// (RL14) Nine-common mode: pump rate bit 0 gives 16kHz, 1 gives 8kHz.
// (RL15) Four/five modes leave commons 1-4 unscanned, released as port pins.
// (RL16) In each common slot, segments show the bit mapped to that segment and common.
// (RL17) Active commons stepped ascending, one slot each; one full pass is a frame.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`include "lsd_consts.vh"

module lsd_scan_driver #(
	parameter SEG_COUNT = 60
) (
	input wire core_clk,
	input wire srst,
	input wire [1:0] duty_select_option,
	input wire osc_is_crystal,
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output reg [8:0] com_out,
	output reg [SEG_COUNT-1:0] seg_out,
	output reg pump_clk,
	output reg frame_pulse,
	output reg sixth_io_port_release
);

localparam integer PUMP_HALF_SLOW = (`LSD_CORE_HZ / (2 * `LSD_PUMP_SLOW_HZ)) - 1;
localparam integer PUMP_HALF_FAST = (`LSD_CORE_HZ / (2 * `LSD_PUMP_FAST_HZ)) - 1;
localparam integer PUMP_HALF_MID = (`LSD_CORE_HZ / (2 * `LSD_PUMP_MID_HZ)) - 1;
localparam integer SLOT_LEN_4 = (2 * `LSD_FRAME_DIV_4COM) / 4;
localparam integer SLOT_LEN_5 = (2 * `LSD_FRAME_DIV_5COM) / 5;
localparam integer SLOT_LEN_9 = (2 * `LSD_FRAME_DIV_9COM) / 9;
localparam integer RC_LAST = `LSD_RC_PRESCALE - 1;

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
// Returns {bank[1:0], offset[5:0]}; bank 0 means not in display memory
function [7:0] ram_decode;
	input [9:0] idx;
	begin
		if (idx >= `LSD_IDX_BANK_A && idx <= `LSD_IDX_BANK_A_END)
			ram_decode = {2'd1, idx[5:0]};
		else if (idx >= `LSD_IDX_BANK_B && idx <= `LSD_IDX_BANK_B_END)
			ram_decode = {2'd2, idx[5:0]};
		else if (idx >= `LSD_IDX_BANK_C && idx <= `LSD_IDX_BANK_C_END)
			ram_decode = {2'd3, idx[5:0] - 6'h00};
		else
			ram_decode = 8'h00;
	end
endfunction

reg [3:0] bank_a [0:SEG_COUNT-1];
reg [3:0] bank_b [0:SEG_COUNT-1];
reg bank_c [0:SEG_COUNT-1];
reg pump_on;
reg display_enable_bit;
reg pump_rate_select_bit;
reg [1:0] duty_mode;
reg bus_ack;
reg [3:0] slot;
reg [7:0] slot_cnt;
reg [1:0] rc_cnt;
reg [11:0] pump_cnt;

wire [9:0] reg_idx = avs_address[11:2];
wire [7:0] dec = ram_decode(reg_idx);
wire [1:0] dec_bank = dec[7:6];
wire [5:0] dec_off = dec[5:0];
wire off_ok = (dec_off < SEG_COUNT);
wire mode_9 = (duty_mode == `LSD_DUTY_9COM_Q);
wire mode_4 = (duty_mode == `LSD_DUTY_4COM_T);
wire outputs_live = pump_on & display_enable_bit;

assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;

// ---------------------------------------------------------------
// Bus slave and registers
// ---------------------------------------------------------------
integer i;
always @(posedge core_clk) begin
	if (srst) begin
		bus_ack <= 1'b0;
		avs_readdata <= 32'h0000_0000;
		pump_on <= `LSD_RST_PUMP_ON;
		display_enable_bit <= `LSD_RST_DISP_ON;
		pump_rate_select_bit <= `LSD_RST_PUMP_RATE;
		duty_mode <= duty_select_option;
		for (i = 0; i < SEG_COUNT; i = i + 1) begin
			bank_a[i] <= 4'h0;
			bank_b[i] <= 4'h0;
			bank_c[i] <= 1'b0;
		end
	end else begin
		bus_ack <= (avs_read | avs_write) & ~bus_ack;
		if ((avs_read | avs_write) & ~bus_ack) begin
			avs_readdata <= 32'h0000_0000;
			if (reg_idx == `LSD_IDX_CTRL) begin
				avs_readdata[`LSD_BIT_PUMP_ON] <= pump_on;
				avs_readdata[`LSD_BIT_DISP_ON] <= display_enable_bit;
			end else if (reg_idx == `LSD_IDX_PUMPCFG) begin
				avs_readdata[`LSD_BIT_PUMP_RATE] <= pump_rate_select_bit;
			end else if (reg_idx == `LSD_IDX_STATUS) begin
				avs_readdata[3:0] <= slot;
				avs_readdata[5:4] <= duty_mode;
			end else if (off_ok && dec_bank == 2'd1) begin
				avs_readdata[3:0] <= bank_a[dec_off];
			end else if (off_ok && dec_bank == 2'd2) begin
				avs_readdata[3:0] <= bank_b[dec_off];
			end else if (off_ok && dec_bank == 2'd3) begin
				avs_readdata[0] <= bank_c[dec_off];
			end
		end
		if (avs_write & bus_ack) begin
			if (reg_idx == `LSD_IDX_CTRL) begin
				pump_on <= avs_writedata[`LSD_BIT_PUMP_ON];
				display_enable_bit <= avs_writedata[`LSD_BIT_DISP_ON];
			end else if (reg_idx == `LSD_IDX_PUMPCFG) begin
				// Rate is frozen while the pump runs
				if (!pump_on)
					pump_rate_select_bit <= avs_writedata[`LSD_BIT_PUMP_RATE];
			end else if (off_ok && dec_bank == 2'd1) begin
				bank_a[dec_off] <= avs_writedata[3:0]; // [RL1]
			end else if (off_ok && dec_bank == 2'd2) begin
				bank_b[dec_off] <= avs_writedata[3:0]; // [RL2]
			end else if (off_ok && dec_bank == 2'd3) begin
				bank_c[dec_off] <= avs_writedata[0]; // [RL3]
			end
		end
	end
end

// ---------------------------------------------------------------
// Display clock and common scan
// ---------------------------------------------------------------
wire disp_tick = osc_is_crystal | (rc_cnt == RC_LAST[1:0]); // [RL8]
reg [7:0] slot_len;
reg [3:0] first_slot;
always @* begin
	case (duty_mode) // [RL12]
		`LSD_DUTY_9COM_Q: begin
			slot_len = SLOT_LEN_9[7:0]; // [RL7]
			first_slot = 4'd0;
		end
		`LSD_DUTY_4COM_T: begin
			slot_len = SLOT_LEN_4[7:0]; // [RL7]
			first_slot = 4'd4;
		end
		default: begin
			slot_len = SLOT_LEN_5[7:0]; // [RL7]
			first_slot = 4'd4;
		end
	endcase
end
wire [3:0] last_slot = mode_4 ? 4'd7 : 4'd8;

always @(posedge core_clk) begin
	if (srst) begin
		rc_cnt <= 2'd0;
		slot_cnt <= 8'd0;
		slot <= 4'd0;
		frame_pulse <= 1'b0;
	end else begin
		rc_cnt <= rc_cnt + 2'd1;
		frame_pulse <= 1'b0;
		if (slot < first_slot || slot > last_slot) begin
			slot <= first_slot;
			slot_cnt <= 8'd0;
		end else if (disp_tick) begin
			if (slot_cnt == slot_len - 8'd1) begin
				slot_cnt <= 8'd0;
				if (slot == last_slot) begin
					slot <= first_slot; // [RL17]
					frame_pulse <= 1'b1;
				end else begin
					slot <= slot + 4'd1; // [RL17]
				end
			end else begin
				slot_cnt <= slot_cnt + 8'd1;
			end
		end
	end
end

// ---------------------------------------------------------------
// Common and segment outputs
// ---------------------------------------------------------------
wire [SEG_COUNT-1:0] next_seg;
genvar g;
generate
	for (g = 0; g < SEG_COUNT; g = g + 1) begin : seg_gen
		// Bank picked by slot range, bit by slot within the bank
		assign next_seg[g] = (slot < 4'd4) ? bank_a[g][slot[1:0]] : // [RL1] [RL16]
			(slot < 4'd8) ? bank_b[g][slot[1:0]] : // [RL2] [RL4] [RL5] [RL16]
			bank_c[g]; // [RL3] [RL5]
	end
endgenerate

always @(posedge core_clk) begin
	if (srst)
		seg_out <= {SEG_COUNT{1'b0}};
	else
		seg_out <= outputs_live ? next_seg : {SEG_COUNT{1'b0}}; // [RL9] [RL13]
end

always @(posedge core_clk) begin
	if (srst) begin
		com_out <= 9'h000;
		sixth_io_port_release <= 1'b0;
	end else begin
		sixth_io_port_release <= ~mode_9; // [RL15]
		com_out <= 9'h000;
		if (outputs_live) // [RL9] [RL13]
			com_out[slot] <= 1'b1; // [RL16]
	end
end

// ---------------------------------------------------------------
// Pump clock
// ---------------------------------------------------------------
reg [11:0] pump_half;
always @* begin
	if (!mode_9)
		pump_half = PUMP_HALF_SLOW[11:0]; // [RL6]
	else if (pump_rate_select_bit)
		pump_half = PUMP_HALF_MID[11:0]; // [RL14]
	else
		pump_half = PUMP_HALF_FAST[11:0]; // [RL14]
end

always @(posedge core_clk) begin
	if (srst || !pump_on) begin
		pump_cnt <= 12'h000;
		pump_clk <= 1'b0;
	end else if (pump_cnt >= pump_half) begin
		pump_cnt <= 12'h000;
		pump_clk <= ~pump_clk; // [RL6]
	end else begin
		pump_cnt <= pump_cnt + 12'h001;
	end
end

endmodule // lsd_scan_driver
